// file: hdl/sfhp_pkg.sv
// What this block does
// R1: bytes 14H..16H read the sector-map table start pointer little-endian as 00H, 01H, 00H.
// R2: byte 17H, the upper identifier byte of the sector-map header, reads FFH and never changes.
// R3: byte 18H reads the maker code that marks the vendor header, a fixed identity value.
// R4: the vendor header reads minor revision 00H at 19H, major revision 01H at 1AH and length 13H at 1BH.
// R5: bytes 1CH..1EH read the vendor table start pointer little-endian as 00H, 02H, 00H.
// R6: byte 1FH reads 01H, a vendor bank number that is not part of the pointer.
// R7: every table start pointer is aligned to four bytes, so its low two bits are zero.
// R8: byte 30H reads FDH with low bits 01 for 4-Kbyte erase, and byte 31H reads the erase opcode 20H.
// R9: bit 2 of byte 30H is 1, a program buffer of at least 64 bytes.
// R10: bit 3 of byte 30H is 1, the status bits are volatile.
// R11: bit 4 of byte 30H is 1, write enable 06H comes before a volatile status write.
// R12: bits 7..5 of byte 30H always read 111b whatever is attempted.
// R13: the header owning the pointer at 14H..16H carries identifier 81H.
// R14: the store is read-only, each read gives the fixed byte and bursts step up by one address.
package sfhp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // ======================================================
  // byte addresses
  localparam logic [7:0] ADR_SMAP_ID = 8'h10;
  localparam logic [7:0] ADR_SMAP_PTR0 = 8'h14;
  localparam logic [7:0] ADR_SMAP_PTR1 = 8'h15;
  localparam logic [7:0] ADR_SMAP_PTR2 = 8'h16;
  localparam logic [7:0] ADR_SMAP_IDHI = 8'h17;
  localparam logic [7:0] ADR_VEND_ID = 8'h18;
  localparam logic [7:0] ADR_VEND_MINOR = 8'h19;
  localparam logic [7:0] ADR_VEND_MAJOR = 8'h1A;
  localparam logic [7:0] ADR_VEND_LEN = 8'h1B;
  localparam logic [7:0] ADR_VEND_PTR0 = 8'h1C;
  localparam logic [7:0] ADR_VEND_PTR1 = 8'h1D;
  localparam logic [7:0] ADR_VEND_PTR2 = 8'h1E;
  localparam logic [7:0] ADR_VEND_BANK = 8'h1F;
  localparam logic [7:0] ADR_FPT_B0 = 8'h30;
  localparam logic [7:0] ADR_FPT_B1 = 8'h31;
  // ======================================================
  // byte values
  localparam logic [7:0] VAL_SMAP_ID = 8'h81;
  localparam logic [23:0] VAL_SMAP_PTR = 24'h000100;
  localparam logic [7:0] VAL_IDHI = 8'hFF;
  localparam logic [7:0] VAL_VEND_MINOR = 8'h00;
  localparam logic [7:0] VAL_VEND_MAJOR = 8'h01;
  localparam logic [7:0] VAL_VEND_LEN = 8'h13;
  localparam logic [23:0] VAL_VEND_PTR = 24'h000200;
  localparam logic [7:0] VAL_VEND_BANK = 8'h01;
  localparam logic [7:0] VAL_ERASE4K_OP = 8'h20;
  localparam logic [7:0] VAL_UNMAPPED = 8'hFF;
  // byte 30H fields
  localparam logic [1:0] FPT_ERASE_4K = 2'h1;
  localparam logic FPT_WGRAN_64 = 1'b1;
  localparam logic FPT_VOL_STAT = 1'b1;
  localparam logic FPT_WEN_06 = 1'b1;
  localparam logic [2:0] FPT_UNUSED = 3'h7;
  localparam logic [1:0] PTR_ALIGN_MASK = 2'h3;
  localparam int ROM_DEPTH = 64;
endpackage

// file: hdl/sfhp_rom.sv
`timescale 1ns/1ps
// ======================================================
// fixed byte table with registered read data
module sfhp_rom #(
  parameter int DEPTH = sfhp_pkg::ROM_DEPTH,
  parameter logic [7:0] MAKER_CODE = 8'h5A // arbitrary neutral value
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] table_byte;

  // decode the address into its constant byte
  always_comb begin
    table_byte = sfhp_pkg::VAL_UNMAPPED;
    unique case (8'(rd_addr))
      sfhp_pkg::ADR_SMAP_ID: table_byte = sfhp_pkg::VAL_SMAP_ID; // see R13
      sfhp_pkg::ADR_SMAP_PTR0: table_byte = sfhp_pkg::VAL_SMAP_PTR[7:0]; // see R1
      sfhp_pkg::ADR_SMAP_PTR1: table_byte = sfhp_pkg::VAL_SMAP_PTR[15:8]; // see R1
      sfhp_pkg::ADR_SMAP_PTR2: table_byte = sfhp_pkg::VAL_SMAP_PTR[23:16]; // see R1
      sfhp_pkg::ADR_SMAP_IDHI: table_byte = sfhp_pkg::VAL_IDHI; // see R2
      sfhp_pkg::ADR_VEND_ID: table_byte = MAKER_CODE; // see R3
      sfhp_pkg::ADR_VEND_MINOR: table_byte = sfhp_pkg::VAL_VEND_MINOR; // see R4
      sfhp_pkg::ADR_VEND_MAJOR: table_byte = sfhp_pkg::VAL_VEND_MAJOR; // see R4
      sfhp_pkg::ADR_VEND_LEN: table_byte = sfhp_pkg::VAL_VEND_LEN; // see R4
      sfhp_pkg::ADR_VEND_PTR0: table_byte = sfhp_pkg::VAL_VEND_PTR[7:0]; // see R5
      sfhp_pkg::ADR_VEND_PTR1: table_byte = sfhp_pkg::VAL_VEND_PTR[15:8]; // see R5
      sfhp_pkg::ADR_VEND_PTR2: table_byte = sfhp_pkg::VAL_VEND_PTR[23:16]; // see R5
      sfhp_pkg::ADR_VEND_BANK: table_byte = sfhp_pkg::VAL_VEND_BANK; // see R6
      // unused bits are constants, so no write path can reach them
      sfhp_pkg::ADR_FPT_B0: table_byte = {sfhp_pkg::FPT_UNUSED, sfhp_pkg::FPT_WEN_06, sfhp_pkg::FPT_VOL_STAT,
                                          sfhp_pkg::FPT_WGRAN_64, sfhp_pkg::FPT_ERASE_4K}; // see R8 R9 R10 R11 R12
      sfhp_pkg::ADR_FPT_B1: table_byte = sfhp_pkg::VAL_ERASE4K_OP; // see R8
      default: table_byte = sfhp_pkg::VAL_UNMAPPED;
    endcase
  end

  // read data from a register
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      rd_data <= table_byte;
    end
  end
endmodule

// file: hdl/sfhp_top.sv
`timescale 1ns/1ps
// ======================================================
// read-only parameter store, byte read port with bursts
module sfhp_top #(
  parameter int DEPTH = sfhp_pkg::ROM_DEPTH,
  parameter logic [7:0] MAKER_CODE = 8'h5A // arbitrary neutral value
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic rd_start,
  input wire logic [7:0] rd_addr,
  input wire logic rd_next,
  output logic [7:0] rd_data,
  output logic rd_valid
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic pend_reg;
  logic [7:0] rom_data;
  logic rom_valid_reg;

  // ======================================================
  // address counter: a start loads, a next steps upward
  always_comb begin
    addr_next = addr_reg;
    if (rd_start) begin
      addr_next = rd_addr;
    end else if (rd_next) begin
      addr_next = addr_reg + 8'h01; // see R14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      addr_reg <= 8'h00;
      pend_reg <= 1'b0;
    end else if (clk_en) begin
      addr_reg <= addr_next;
      pend_reg <= rd_start | rd_next;
    end
  end

  // addresses beyond the table wrap inside it; no write path exists
  sfhp_rom #(.DEPTH(DEPTH), .MAKER_CODE(MAKER_CODE)) u_rom (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .rd_addr(addr_reg[AW-1:0]),
    .rd_data(rom_data)
  );

  // ======================================================
  // output stage, one more register so ports come from flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rom_valid_reg <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else if (clk_en) begin
      rom_valid_reg <= pend_reg;
      rd_valid <= rom_valid_reg;
      rd_data <= rom_valid_reg ? rom_data : 8'h00;
    end
  end

  // ======================================================
  // checks
  localparam logic [1:0] PTR_MASK = sfhp_pkg::PTR_ALIGN_MASK;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || !clk_en);

  sequence s_ask(logic [7:0] a);
    rd_start && rd_addr == a && clk_en;
  endsequence

  AST_SMAP_PTR: assert property (s_ask(8'h14) ##1 clk_en[*3] |-> rd_valid && rd_data == 8'h00) // see R1
    else $error("sector map pointer low byte wrong");
  AST_SMAP_PTR1: assert property (s_ask(8'h15) ##1 clk_en[*3] |-> rd_valid && rd_data == 8'h01) // see R1
    else $error("sector map pointer mid byte wrong");
  AST_IDHI: assert property (s_ask(8'h17) ##1 clk_en[*3] |-> rd_data == 8'hFF) // see R2
    else $error("id msb not FF");
  AST_VLEN: assert property (s_ask(8'h1B) ##1 clk_en[*3] |-> rd_data == 8'h13) // see R4
    else $error("vendor length wrong");
  AST_MAKER: assert property (s_ask(8'h18) ##1 clk_en[*3] |-> rd_data == MAKER_CODE) // see R3
    else $error("maker byte wrong");
  AST_VPTR: assert property (s_ask(8'h1D) ##1 clk_en[*3] |-> rd_data == 8'h02) // see R5
    else $error("vendor pointer wrong");
  AST_BANK: assert property (s_ask(8'h1F) ##1 clk_en[*3] |-> rd_data == 8'h01) // see R6
    else $error("bank byte wrong");
  AST_ALIGN: assert property (s_ask(8'h1C) ##1 clk_en[*3] |-> (rd_data[1:0] & PTR_MASK) == 2'h0) // see R7
    else $error("pointer not aligned");
  AST_FPT0: assert property (s_ask(8'h30) ##1 clk_en[*3] |-> rd_data == 8'hFD && rd_data[7:5] == 3'h7) // see R8 R12
    else $error("byte 30 wrong");
  AST_WGRAN: assert property (s_ask(8'h30) ##1 clk_en[*3] |-> rd_data[2] && rd_data[3] && rd_data[4]) // see R9 R10 R11
    else $error("byte 30 flags wrong");
  AST_OPC: assert property (s_ask(8'h31) ##1 clk_en[*3] |-> rd_data == 8'h20) // see R8
    else $error("erase opcode wrong");
  AST_SMID: assert property (s_ask(8'h10) ##1 clk_en[*3] |-> rd_data == 8'h81) // see R13
    else $error("sector map id wrong");
  AST_STEP: assert property (clk_en && !rd_start && rd_next |=> addr_reg == $past(addr_reg) + 8'h01) // see R14
    else $error("burst address did not step");
  AST_LAT: assert property ((clk_en && (rd_start || rd_next)) ##1 clk_en[*3] |-> rd_valid) // see R14
    else $error("read answer late");
  // a quiet port shows zero, so a stale byte is never mistaken for an answer
  AST_IDLE_DATA: assert property (!rd_valid |-> rd_data == 8'h00) // see R14
    else $error("data shown without an answer");
endmodule

// file: bench/sfhp_host_model.sv
`timescale 1ns/1ps
// ======================================================
// host side: issues byte reads and gathers the answers
module sfhp_host_model (
  input wire logic sys_clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output logic rd_start,
  output logic [7:0] rd_addr,
  output logic rd_next
);
  logic [7:0] got[$];
  // idle address is not held, so a stale value cannot pass
  initial begin
    rd_start = 1'b0;
    rd_next = 1'b0;
    rd_addr = 8'hA5;
  end
  // one byte is gathered per valid cycle
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) got.push_back(rd_data);
  end
  // one start then n-1 steps; changes only at falling edges
  task automatic burst(input logic [7:0] addr, input int n);
    @(negedge sys_clk);
    rd_start = 1'b1;
    rd_addr = addr;
    for (int i = 1; i < n; i++) begin
      @(negedge sys_clk);
      rd_start = 1'b0;
      rd_addr = ~addr;
      rd_next = 1'b1;
    end
    @(negedge sys_clk);
    rd_start = 1'b0;
    rd_next = 1'b0;
    rd_addr = ~addr;
  endtask
endmodule

// file: bench/sfhp_header_param_rom_tb.sv
`timescale 1ns/1ps
// ======================================================
// bench for the parameter store
module sfhp_header_param_rom_tb;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic rd_start, rd_next, rd_valid;
  logic [7:0] rd_addr, rd_data;
  int fails = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  sfhp_top #(.MAKER_CODE(MAKER)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .rd_start(rd_start), .rd_addr(rd_addr), .rd_next(rd_next), .rd_data(rd_data), .rd_valid(rd_valid));
  sfhp_host_model host (.sys_clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_start(rd_start), .rd_addr(rd_addr), .rd_next(rd_next));
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // expected bytes of the header dwords
  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    case (a)
      8'h15, 8'h1A, 8'h1F: exp_byte = 8'h01;
      8'h17: exp_byte = 8'hFF;
      8'h18: exp_byte = MAKER;
      8'h1B: exp_byte = 8'h13;
      8'h1D: exp_byte = 8'h02;
      default: exp_byte = 8'h00;
    endcase
  endfunction
  // whole burst across the three header dwords 14H..1FH, ascending
  task burst_header();
    host.got.delete();
    host.burst(8'h14, 12);
    for (int w = 0; w < 20 && host.got.size() < 12; w++) @(posedge sys_clk);
    check("burst count", 8'(host.got.size()), 8'h0C);
    for (int i = 0; i < 12; i++) check("hdr byte", host.got[i], exp_byte(8'h14 + 8'(i)));
    check("smap ptr low bits", {6'h0, host.got[0][1:0]}, 8'h00);
    check("vend ptr low bits", {6'h0, host.got[8][1:0]}, 8'h00);
  endtask
  // single read: exactly three edges, stands one cycle
  task single(input logic [7:0] a, input logic [7:0] exp, output logic [7:0] seen);
    host.burst(a, 1);
    @(posedge sys_clk);
    #1 check("early valid", {7'h0, rd_valid}, 8'h00);
    @(posedge sys_clk);
    #1 check("valid", {7'h0, rd_valid}, 8'h01);
    seen = rd_data;
    check("single byte", rd_data, exp);
    @(posedge sys_clk);
    #1 check("valid drop", {7'h0, rd_valid}, 8'h00);
  endtask
  // first parameter dword, each field on its own except bits 4..2, which are checked together
  // the byte is kept from its valid cycle, the port is back to zero afterwards
  task param_fields();
    logic [7:0] b;
    single(8'h10, 8'h81, b);
    single(8'h31, 8'h20, b);
    single(8'h20, 8'hFF, b);
    single(8'h50, 8'h81, b);
    single(8'h30, 8'hFD, b);
    check("erase size", {6'h0, b[1:0]}, 8'h01);
    check("fields", {5'h0, b[4:2]}, 8'h07);
    check("unused", {5'h0, b[7:5]}, 8'h07);
  endtask
  // clock enable low freezes the read in flight
  task freeze();
    host.burst(8'h1D, 1);
    clk_en = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 check("frozen", {7'h0, rd_valid}, 8'h00);
    @(negedge sys_clk);
    clk_en = 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1 check("thawed", {rd_valid, rd_data[6:0]}, 8'h82);
  endtask
  task complete_run();
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog far beyond the fewer than one hundred cycles needed
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 check("reset out", {rd_valid, rd_data[6:0]}, 8'h00);
    @(negedge sys_clk);
    reset_n = 1'b1;
    burst_header();
    param_fields();
    freeze();
    complete_run();
  end
endmodule
